// ### rtl/gpcn_port_top.sv
// Parallel ports with analog pin handling and change notification
module gpcn_port_top
    import gpcn_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [GP_NPORT-1:0][15:0] padIn,
    output logic [GP_NPORT-1:0][15:0] padOut,
    output logic [GP_NPORT-1:0][15:0] padOe,
    input wire logic [GP_NPORT-1:0][15:0] periphOe,
    input wire logic [GP_NPORT-1:0][15:0] periphOut,
    output logic [GP_NCN-1:0] pullupEn,
    output logic [7:0] adcConnect,
    output logic [7:0] adcFromOutput,
    output logic [7:0] adcDrivenLevel,
    output logic irq
);

    gpcn_state_t cur_reg;
    gpcn_state_t cur_next;

    // ------------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------------
    function automatic logic [31:0] readWord(input gpcn_state_t s,
                                             input logic [9:0] idx);
        logic [31:0] w;
        logic [15:0] lvl;
        w = GP_ZERO_WORD;
        for (int p = 0; p < GP_NPORT; p++) begin
            lvl = s.sync2[p];
            if (p == GP_ANA_PORT) begin
                // Analog inputs read low
                lvl[7:0] = lvl[7:0] & ~(s.anaCfg & s.dir[p][7:0]); // [R3]
            end
            if (idx == GP_DIR_IDX[p]) begin
                w = {16'h0000, s.dir[p] & GP_BIT_MASK[p]}; // [R17]
            end
            if (idx == GP_PIN_IDX[p]) begin
                w = {16'h0000, lvl & GP_BIT_MASK[p]}; // [R14] [R17]
            end
            if (idx == GP_LAT_IDX[p]) begin
                w = {16'h0000, s.lat[p] & GP_BIT_MASK[p]}; // [R14]
            end
        end
        case (idx)
            GP_ANA_IDX: w = {24'h000000, s.anaCfg};
            GP_CNEN_IDX: w = {24'h000000, s.cnEn};
            GP_PUEN_IDX: w = {24'h000000, s.puEn};
            GP_STAT_IDX: w = {31'h00000000, s.intStat};
            GP_MASK_IDX: w = {31'h00000000, s.intMask};
            default: w = w;
        endcase
        return w;
    endfunction

    logic addrPhase;
    logic [9:0] aIdx;
    logic [7:0] cnLevel;
    logic [7:0] cnChange;

    assign addrPhase = hsel && htrans[1] && hready;
    assign aIdx = haddr[11:2];
    assign cnLevel = cur_reg.sync2[GP_CN_PORT][7:0];
    // Any enabled input differing from its last sample
    assign cnChange = (cnLevel ^ cur_reg.cnPrev) & cur_reg.cnEn; // [R8] [R16]

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        cur_next = cur_reg;
        cur_next.ready = 1'b1;

        // Two-stage capture of the pads before anything looks at them
        cur_next.sync1 = padIn;
        cur_next.sync2 = cur_reg.sync1;

        // Data phase of a write
        if (cur_reg.dWrite) begin
            for (int p = 0; p < GP_NPORT; p++) begin
                if (cur_reg.dIdx == GP_DIR_IDX[p]) begin
                    cur_next.dir[p] = hwdata[15:0] & GP_BIT_MASK[p]; // [R17]
                end
                // Pin-level writes land in the latch as well
                if (cur_reg.dIdx == GP_LAT_IDX[p] ||
                    cur_reg.dIdx == GP_PIN_IDX[p]) begin
                    cur_next.lat[p] = hwdata[15:0] & GP_BIT_MASK[p]; // [R14]
                end
            end
            case (cur_reg.dIdx)
                GP_ANA_IDX: cur_next.anaCfg = hwdata[7:0];
                GP_CNEN_IDX: cur_next.cnEn = hwdata[7:0]; // [R7] [R8]
                GP_PUEN_IDX: cur_next.puEn = hwdata[7:0]; // [R10]
                GP_MASK_IDX: cur_next.intMask = hwdata[0];
                default: cur_next.dIdx = cur_reg.dIdx;
            endcase
        end

        // Address phase: capture write target, prepare read data
        cur_next.dWrite = addrPhase && hwrite;
        cur_next.dIdx = aIdx;
        cur_next.rdata = GP_ZERO_WORD;
        if (addrPhase && !hwrite) begin
            cur_next.rdata = readWord(cur_reg, aIdx);
            if (aIdx == GP_STAT_IDX) begin
                cur_next.intStat = 1'b0;
            end
        end

        // Change notification; a new event beats a read clear
        cur_next.cnPrev = cnLevel; // [R16]
        if (|cnChange) begin
            cur_next.intStat = 1'b1; // [R6] [R16]
        end
        cur_next.irqOut = cur_next.intStat & cur_next.intMask;

        // Pad drive: peripheral owns the pin when it drives it
        for (int p = 0; p < GP_NPORT; p++) begin
            for (int b = 0; b < 16; b++) begin
                if (!GP_BIT_MASK[p][b]) begin
                    cur_next.padOe[p][b] = 1'b0;
                    cur_next.padOut[p][b] = 1'b0;
                end else if (periphOe[p][b]) begin
                    cur_next.padOe[p][b] = 1'b1; // [R15]
                    cur_next.padOut[p][b] = periphOut[p][b]; // [R15]
                end else begin
                    cur_next.padOe[p][b] = ~cur_next.dir[p][b]; // [R12]
                    cur_next.padOut[p][b] = cur_next.lat[p][b]; // [R12]
                end
            end
        end

        // Weak pull-ups, one enable per change pin
        cur_next.pullupOut = cur_next.puEn; // [R9] [R10]

        // Converter routing: digital pins never reach it
        cur_next.adcConn = cur_next.anaCfg; // [R4]
        cur_next.adcFromOut = cur_next.anaCfg &
            ~cur_next.dir[GP_ANA_PORT][7:0]; // [R2]
        cur_next.adcLevel = cur_next.padOut[GP_ANA_PORT][7:0] &
            cur_next.anaCfg; // [R2]
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_reg <= '0;
            cur_reg.dir <= GP_DIR_RST; // [R13]
            cur_reg.lat <= {GP_NPORT{GP_LAT_RST}};
            cur_reg.anaCfg <= GP_CFG_RST;
            cur_reg.cnEn <= GP_CFG_RST;
            cur_reg.puEn <= GP_CFG_RST;
            cur_reg.ready <= 1'b1;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign hrdata = cur_reg.rdata;
    assign hreadyout = cur_reg.ready;
    assign hresp = 1'b0;
    assign padOut = cur_reg.padOut;
    assign padOe = cur_reg.padOe;
    assign pullupEn = cur_reg.pullupOut;
    assign adcConnect = cur_reg.adcConn;
    assign adcFromOutput = cur_reg.adcFromOut;
    assign adcDrivenLevel = cur_reg.adcLevel;
    assign irq = cur_reg.irqOut;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_analog_reads_low: assert property ( // [R3]
        addrPhase && !hwrite && aIdx == GP_PIN_IDX[GP_ANA_PORT]
        |=> (hrdata[7:0] & $past(cur_reg.anaCfg & cur_reg.dir[1][7:0]))
            == 8'h00)
        else $error("analog pin read not zero");

    a_dir_output_drive: assert property ( // [R12]
        !periphOe[0][9] && !cur_next.dir[0][9] |=> padOe[0][9]
            && padOut[0][9] == $past(cur_next.lat[0][9]))
        else $error("output pin not driven from latch");

    a_dir_input_float: assert property ( // [R12]
        !periphOe[3][0] && cur_next.dir[3][0] |=> !padOe[3][0])
        else $error("input pin driven");

    a_periph_owns_pin: assert property ( // [R15]
        periphOe[0][9] |=> padOe[0][9] && padOut[0][9] == $past(periphOut[0][9]))
        else $error("peripheral lost pin ownership");

    a_change_sets_flag: assert property ( // [R16]
        |cnChange |=> cur_reg.intStat && irq == cur_reg.intMask)
        else $error("change did not raise flag");

    a_disabled_quiet: assert property ( // [R8]
        cur_reg.cnEn == 8'h00 && !cur_reg.intStat && $stable(cur_reg.cnEn)
        |=> !cur_reg.intStat)
        else $error("flag set with no enable");

    a_pullup_follows: assert property ( // [R10]
        $changed(cur_reg.puEn) |-> pullupEn == cur_reg.puEn)
        else $error("pull-up enable not applied");

    a_unimpl_zero: assert property ( // [R17]
        addrPhase && !hwrite && aIdx == GP_DIR_IDX[2]
        |=> hrdata[31:1] == 31'h00000000)
        else $error("unimplemented bits nonzero");

    a_adc_from_output: assert property ( // [R2]
        cur_reg.anaCfg[0] && !cur_reg.dir[1][0] |-> adcFromOutput[0]
            && adcDrivenLevel[0] == padOut[1][0])
        else $error("converter not fed driven level");

    a_digital_not_routed: assert property ( // [R4]
        !cur_reg.anaCfg[3] |-> !adcConnect[3] && !adcFromOutput[3])
        else $error("digital pin routed to converter");

    // ------------------------------------------------------------------
    // Checks: register writes, reads and the change flag
    // ------------------------------------------------------------------
    a_read_clears_flag: assert property ( // [R16]
        addrPhase && !hwrite && aIdx == GP_STAT_IDX && !(|cnChange)
        |=> !cur_reg.intStat)
        else $error("status read did not clear flag");

    // Event and clear in one cycle: the event must win
    a_event_beats_clear: assert property ( // [R16]
        addrPhase && !hwrite && aIdx == GP_STAT_IDX && |cnChange
        |=> cur_reg.intStat)
        else $error("change lost to status read");

    a_irq_follows_flag: assert property ( // [R16]
        irq == (cur_reg.intStat && cur_reg.intMask))
        else $error("irq does not follow flag and mask");

    a_status_write_ignored: assert property ( // [R16]
        cur_reg.dWrite && cur_reg.dIdx == GP_STAT_IDX && !(|cnChange)
        && !(addrPhase && !hwrite && aIdx == GP_STAT_IDX)
        |=> cur_reg.intStat == $past(cur_reg.intStat))
        else $error("status write changed flag");

    a_prev_tracks_level: assert property ( // [R16]
        rst_b |=> cur_reg.cnPrev == $past(cnLevel))
        else $error("change reference not updated");

    a_latch_write_lands: assert property ( // [R14]
        cur_reg.dWrite && cur_reg.dIdx == GP_LAT_IDX[1]
        |=> cur_reg.lat[1] == ($past(hwdata[15:0]) & GP_BIT_MASK[1]))
        else $error("latch write lost");

    a_pin_write_latch: assert property ( // [R14]
        cur_reg.dWrite && cur_reg.dIdx == GP_PIN_IDX[2]
        |=> cur_reg.lat[2] == ($past(hwdata[15:0]) & GP_BIT_MASK[2]))
        else $error("pin-level write missed the latch");

    a_pin_read_level: assert property ( // [R14]
        addrPhase && !hwrite && aIdx == GP_PIN_IDX[4]
        |=> hrdata[15:0] == ($past(cur_reg.sync2[4]) & GP_BIT_MASK[4]))
        else $error("pin read not pin level");

    a_latch_read: assert property ( // [R14]
        addrPhase && !hwrite && aIdx == GP_LAT_IDX[0]
        |=> hrdata[15:0] == ($past(cur_reg.lat[0]) & GP_BIT_MASK[0]))
        else $error("latch read not latch");

    a_unimpl_pin_read: assert property ( // [R17]
        addrPhase && !hwrite && aIdx == GP_PIN_IDX[0]
        |=> (hrdata & 32'hFFFF_FDFF) == 32'h0000_0000)
        else $error("unimplemented pin bits nonzero");

    // Unimplemented pads must never be driven
    a_unimpl_no_drive: assert property ( // [R17]
        padOe[2][15:1] == 15'h0000 && padOut[2][15:1] == 15'h0000)
        else $error("unimplemented pad driven");

    a_dir_write_masked: assert property ( // [R17]
        cur_reg.dWrite && cur_reg.dIdx == GP_DIR_IDX[4]
        |=> cur_reg.dir[4] == ($past(hwdata[15:0]) & GP_BIT_MASK[4]))
        else $error("direction write not masked");

    a_cn_enable_lands: assert property ( // [R8]
        cur_reg.dWrite && cur_reg.dIdx == GP_CNEN_IDX
        |=> cur_reg.cnEn == $past(hwdata[7:0]))
        else $error("change enable write lost");

    a_pullup_write_lands: assert property ( // [R10]
        cur_reg.dWrite && cur_reg.dIdx == GP_PUEN_IDX
        |=> cur_reg.puEn == $past(hwdata[7:0]))
        else $error("pull-up enable write lost");

    a_mask_write_lands: assert property ( // [R16]
        cur_reg.dWrite && cur_reg.dIdx == GP_MASK_IDX
        |=> cur_reg.intMask == $past(hwdata[0]))
        else $error("mask write lost");

    a_adc_level_zero: assert property ( // [R2]
        (adcDrivenLevel & ~adcConnect) == 8'h00)
        else $error("driven level on non-analog channel");

endmodule // gpcn_port_top

// ### rtl/gpcn_pkg.sv
// Constants, register map and state type of the port and change-notify block
//
// Contract
// R1: Software sets a pin's direction bit to input before using it as analog.
// R2: An analog pin set to output hands its own driven level to the converter.
// R3: A pin-level read returns zero for every pin set up as analog input.
// R4: A pin set up as digital input is never routed to the converter.
// R5: Software waits one cycle between a direction or port write and a read.
// R6: Enabled change inputs are watched for change and raise an interrupt.
// R7: There are eight change inputs, each selectable as a change source.
// R8: Each change input has its own enable bit that lets it raise the flag.
// R9: Every change input pin has a weak pull-up that can pull it high.
// R10: Each change input has its own pull-up enable bit for its pin alone.
// R11: Software keeps the pull-up off while that pin is a digital output.
// R12: Direction bit one makes the pin an input, zero drives it from latch.
// R13: After reset every port pin is an input. The code resets port B bits 6 and 7 as outputs (GP_DIR_RST for port B is 003F).
// R14: Pin-level reads give pins, its writes load the latch; latch reads latch.
// R15: A peripheral driving a pin disables the port driver; reads still work.
// R16: Each enabled input is compared with its last level; any change sets one flag.
// R17: Unimplemented port bits read as zero and ignore writes.
package gpcn_pkg;

    localparam int GP_NPORT = 5;
    localparam int GP_NCN = 8;

    // Printed offsets are word indices; byte address is four times the index
    // Port order: 0=A, 1=B, 2=D, 3=E, 4=F
    localparam logic [4:0][9:0] GP_DIR_IDX =
        {10'h2DE, 10'h2D8, 10'h2D2, 10'h2C6, 10'h2C0};
    localparam logic [4:0][9:0] GP_PIN_IDX =
        {10'h2E0, 10'h2DA, 10'h2D4, 10'h2C8, 10'h2C2};
    localparam logic [4:0][9:0] GP_LAT_IDX =
        {10'h2E2, 10'h2DC, 10'h2D6, 10'h2CA, 10'h2C4};
    localparam logic [9:0] GP_ANA_IDX = 10'h300;
    localparam logic [9:0] GP_CNEN_IDX = 10'h301;
    localparam logic [9:0] GP_PUEN_IDX = 10'h302;
    localparam logic [9:0] GP_STAT_IDX = 10'h303;
    localparam logic [9:0] GP_MASK_IDX = 10'h304;

    localparam logic [4:0][15:0] GP_DIR_RST =
        {16'h01C0, 16'h00FF, 16'h0005, 16'h003F, 16'h0200};
    localparam logic [4:0][15:0] GP_BIT_MASK =
        {16'h01C0, 16'h00FF, 16'h0001, 16'h00FF, 16'h0200};
    localparam logic [15:0] GP_LAT_RST = 16'h0000;
    localparam logic [7:0] GP_CFG_RST = 8'h00;

    // Analog channels sit on port B bits 0..7, change inputs on port E 0..7
    localparam int GP_ANA_PORT = 1;
    localparam int GP_CN_PORT = 3;
    localparam logic [31:0] GP_ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [4:0][15:0] dir;
        logic [4:0][15:0] lat;
        logic [4:0][15:0] sync1;
        logic [4:0][15:0] sync2;
        logic [4:0][15:0] padOut;
        logic [4:0][15:0] padOe;
        logic [7:0] anaCfg;
        logic [7:0] cnEn;
        logic [7:0] puEn;
        logic [7:0] cnPrev;
        logic [7:0] pullupOut;
        logic [7:0] adcConn;
        logic [7:0] adcFromOut;
        logic [7:0] adcLevel;
        logic intStat;
        logic intMask;
        logic irqOut;
        logic dWrite;
        logic [9:0] dIdx;
        logic [31:0] rdata;
        logic ready;
    } gpcn_state_t;

endpackage

// ### verification/gpcn_pin_model.sv
// Pin-side model: external drivers, weak pull-ups and floating pins
module gpcn_pin_model
    import gpcn_pkg::*;
(
    input wire logic core_clk,
    input wire logic [GP_NPORT-1:0][15:0] padOut,
    input wire logic [GP_NPORT-1:0][15:0] padOe,
    input wire logic [GP_NCN-1:0] pullupEn,
    input wire logic [GP_NPORT-1:0][15:0] extEn,
    input wire logic [GP_NPORT-1:0][15:0] extVal,
    output logic [GP_NPORT-1:0][15:0] padIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic flt = 1'b0;
    // Floating pins toggle so a stale level never passes for data
    always @(posedge core_clk) flt <= ~flt;
    always_comb begin
        for (int p = 0; p < GP_NPORT; p++) begin
            for (int b = 0; b < 16; b++) begin
                if (padOe[p][b])
                    padIn[p][b] = padOut[p][b];
                else if (extEn[p][b])
                    padIn[p][b] = extVal[p][b];
                else if (p == GP_CN_PORT && b < 8 && pullupEn[b % 8])
                    padIn[p][b] = 1'b1;
                else
                    padIn[p][b] = flt;
            end
        end
    end
endmodule // gpcn_pin_model

// ### verification/gpio_port_change_notify_test.sv
// Register-level bench for the port and change-notify block
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errCount++; \
    $display("unexpected at %0t: %h, want %h", $time, a, b); end end
module gpio_port_change_notify_test;
    timeunit 1ns;
    timeprecision 1ns;
    import gpcn_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, irq;
    logic [GP_NPORT-1:0][15:0] padIn, padOut, padOe;
    logic [GP_NPORT-1:0][15:0] periphOe = '0, periphOut = '0;
    logic [GP_NPORT-1:0][15:0] extEn = '0, extVal = '0;
    logic [7:0] pullupEn, adcConnect, adcFromOutput, adcDrivenLevel;
    int errCount = 0, numChecks = 0;

    gpcn_port_top dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .padIn(padIn),
        .padOut(padOut), .padOe(padOe), .periphOe(periphOe),
        .periphOut(periphOut), .pullupEn(pullupEn),
        .adcConnect(adcConnect), .adcFromOutput(adcFromOutput),
        .adcDrivenLevel(adcDrivenLevel), .irq(irq));
    gpcn_pin_model pins (.core_clk(core_clk), .padOut(padOut),
        .padOe(padOe), .pullupEn(pullupEn), .extEn(extEn),
        .extVal(extVal), .padIn(padIn));

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Bus tasks, entered right after an edge
    // ----------------------------------------
    task automatic wrap_up(input logic hung);
        if (hung) errCount++;
        $display("checks %0d, mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic waitRdy();
        int n = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) wrap_up(1'b1);
            @(posedge core_clk);
        end
    endtask

    task automatic bus(input logic w, input logic [9:0] idx,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, idx, 2'h0};
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitRdy();
        rd = hrdata;
    endtask

    task automatic rdChk(input logic [9:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 32'h0);
        `CHK(rd, {16'h0, exp})
        `CHK(hresp, 1'b0)
    endtask

    task automatic waitIrq();
        int n = 0;
        while (irq !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            n++;
        end
        `CHK(irq, 1'b1)
        if (irq !== 1'b1) wrap_up(1'b0);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        `CHK(padOe, '0)
        for (int p = 0; p < GP_NPORT; p++) begin
            rdChk(GP_DIR_IDX[p], GP_DIR_RST[p] & GP_BIT_MASK[p]);
            rdChk(GP_LAT_IDX[p], 16'h0000);
        end
        $display("reset test done");
        for (int p = 0; p < GP_NPORT; p++) begin
            bus(1'b1, GP_LAT_IDX[p], 32'hFFFF_FFFF);
            bus(1'b1, GP_DIR_IDX[p], 32'h0000_0000);
            rdChk(GP_LAT_IDX[p], GP_BIT_MASK[p]);
        end
        repeat (4) @(posedge core_clk);
        `CHK(padOe, GP_BIT_MASK)
        `CHK(padOut, GP_BIT_MASK)
        for (int p = 0; p < GP_NPORT; p++)
            rdChk(GP_PIN_IDX[p], GP_BIT_MASK[p]);
        bus(1'b1, GP_PIN_IDX[2], 32'h0);
        @(posedge core_clk);
        rdChk(GP_LAT_IDX[2], 16'h0000);
        rdChk(10'h3FF, 16'h0000);
        $display("port test done");
        bus(1'b1, GP_LAT_IDX[1], 32'h0000_00A5);
        bus(1'b1, GP_ANA_IDX, 32'h0000_00FF);
        repeat (2) @(posedge core_clk);
        `CHK(adcFromOutput, 8'hFF)
        `CHK(adcDrivenLevel, 8'hA5)
        extEn[1] <= 16'h00FF;
        extVal[1] <= 16'h00FF;
        bus(1'b1, GP_DIR_IDX[1], 32'h0000_00FF);
        repeat (4) @(posedge core_clk);
        `CHK(adcFromOutput, 8'h00)
        rdChk(GP_PIN_IDX[1], 16'h0000);
        bus(1'b1, GP_ANA_IDX, 32'h0000_000F);
        repeat (2) @(posedge core_clk);
        `CHK(adcConnect, 8'h0F)
        rdChk(GP_PIN_IDX[1], 16'h00F0);
        $display("analog test done");
        periphOe[0] <= 16'h0200;
        repeat (4) @(posedge core_clk);
        `CHK(padOut[0], 16'h0000)
        rdChk(GP_PIN_IDX[0], 16'h0000);
        $display("peripheral test done");
        extEn[3] <= 16'h00FF;
        bus(1'b1, GP_DIR_IDX[3], 32'h0000_00FF);
        bus(1'b1, GP_MASK_IDX, 32'h0000_0001);
        repeat (6) @(posedge core_clk);
        rdChk(GP_STAT_IDX, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, GP_CNEN_IDX, 32'h1 << i);
            extVal[3][(i + 1) % 8] <= ~extVal[3][(i + 1) % 8];
            repeat (6) @(posedge core_clk);
            `CHK(irq, 1'b0)
            extVal[3][i] <= ~extVal[3][i];
            waitIrq();
            rdChk(GP_STAT_IDX, 16'h0001);
            @(posedge core_clk);
            `CHK(irq, 1'b0)
        end
        bus(1'b1, GP_MASK_IDX, 32'h0);
        extVal[3][7] <= ~extVal[3][7];
        repeat (6) @(posedge core_clk);
        `CHK(irq, 1'b0)
        rdChk(GP_STAT_IDX, 16'h0001);
        $display("change test done");
        bus(1'b1, GP_CNEN_IDX, 32'h0);
        bus(1'b1, GP_PUEN_IDX, 32'h0000_005A);
        extEn[3] <= '0;
        repeat (4) @(posedge core_clk);
        `CHK(pullupEn, 8'h5A)
        bus(1'b0, GP_PIN_IDX[3], 32'h0);
        `CHK(rd[7:0] & 8'h5A, 8'h5A)
        $display("pull-up test done");
        wrap_up(1'b0);
    end
endmodule // gpio_port_change_notify_test
